// [inc/rtie_pkg.sv]
// Package with the register map, field positions, reset values and event type.
package rtie_pkg;

    // ============================================================
    // Register indices; each register sits at byte address 4 * index.
    localparam logic [7:0] IDX_THR = 8'h8E;
    localparam logic [7:0] IDX_EN = 8'h90;
    localparam logic [7:0] IDX_STAT = 8'h92;
    localparam logic [7:0] IDX_CLR = 8'h94;
    localparam logic [7:0] IDX_QCTL = 8'h96;
    localparam int ADR_W = 10;

    // ============================================================
    // Reset values and access masks.
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [15:0] EN_RST = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0300;
    localparam logic [15:0] QCTL_RST = 16'h0000;
    localparam logic [15:0] STAT_IMPL = 16'hEB7D;
    localparam logic [15:0] EN_WR = 16'hFFFD;
    localparam logic [15:0] QCTL_WR = 16'h0040;

    // ============================================================
    // Bit positions of the status and enable layout, and of the queue control enable.
    localparam int B_LINK = 15;
    localparam int B_TX = 14;
    localparam int B_RX = 13;
    localparam int B_OVR = 11;
    localparam int B_TXSTOP = 9;
    localparam int B_RXSTOP = 8;
    localparam int B_TXSPACE = 6;
    localparam int B_WFRAME = 5;
    localparam int B_RWAKE = 4;
    localparam int B_LINKUP = 3;
    localparam int B_ENERGY = 2;
    localparam int B_RSV1 = 1;
    localparam int B_DELAY = 0;
    localparam int B_QTHR_EN = 6;

    // ============================================================
    // Event pulses, laid out in the same order as the status bits.
    typedef struct packed {
        logic link_change;
        logic tx_done;
        logic rx_ready;
        logic rsv12;
        logic rx_overrun;
        logic rsv10;
        logic tx_stopped;
        logic rx_stopped;
        logic rsv7;
        logic tx_space;
        logic wake_frame;
        logic remote_wake;
        logic linkup_wake;
        logic energy_wake;
        logic rsv1;
        logic delayed_energy;
    } rtie_evt_t;

endpackage : rtie_pkg

// [hw/rtie_top.sv]
// Interrupt enable bank with receive byte-count threshold and Wishbone slave.
`timescale 1ns/1ps
// What this block does
// R01 - Sixteen-bit threshold register, read-write, resets zero.
// R02 - Queue byte count over threshold sets receive status.
// R03 - Enable bit 15 gates link change interrupt.
// R04 - Enable bit 14 gates transmit interrupt.
// R05 - Enable bit 13 gates receive interrupt.
// R06 - Enable bit 11 gates receive overrun interrupt.
// R07 - Enable bit 9 gates transmit stopped interrupt.
// R08 - Enable bit 8 gates receive stopped interrupt.
// R09 - Enable bit 6 gates transmit space interrupt.
// R10 - Enable bit 5 gates wake frame interrupt.
// R11 - Enable bit 4 gates remote wake interrupt.
// R12 - Enable bit 3 gates link-up wake interrupt.
// R13 - Enable bit 2 gates energy wake interrupt.
// R14 - Enable bit 0 gates delayed energy, held till ready.
// R15 - Enable bits reset zero; bit 1 read-only.
// R16 - Pin asserts while any enabled status bit set, bit 0 only while host ready.
// R17 - Reads keep status; writing one to the clear register clears it.
module rtie_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rtie_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input rtie_pkg::rtie_evt_t evt_i,
    input wire logic [15:0] rx_queue_bytes_i,
    input wire logic host_ready_i,
    output logic irq_o
);

    // ============================================================
    // Bus decode.
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [15:0] wmask;
    logic [15:0] wdat;

    // The first cycle of a request fetches read data; the ack cycle commits writes.
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_reg;
        wr = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;
        rd = wb_cyc_i & wb_stb_i & ack_reg & ~wb_we_i;
        idx = wb_adr_i[rtie_pkg::ADR_W-1:2];
        wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wdat = wb_dat_i[15:0] & wmask;
    end

    // ============================================================
    // Registers.
    logic [15:0] thr_reg;
    logic [15:0] thr_next;
    logic [15:0] en_reg;
    logic [15:0] en_next;
    logic [15:0] qctl_reg;
    logic [15:0] qctl_next;
    logic [15:0] stat_reg;
    logic [15:0] stat_next;
    logic cond_reg;
    logic cond_next;
    logic irq_reg;
    logic irq_next;
    logic [15:0] clr;
    logic [15:0] set;
    logic [15:0] gate;

    // Next values of the software registers and the sticky status.
    always_comb begin
        thr_next = thr_reg;
        en_next = en_reg;
        qctl_next = qctl_reg;
        clr = 16'h0000;
        if (wr && idx == rtie_pkg::IDX_THR) begin
            thr_next = (thr_reg & ~wmask) | wdat; // R01
        end
        if (wr && idx == rtie_pkg::IDX_EN) begin
            en_next = ((en_reg & ~wmask) | wdat) & rtie_pkg::EN_WR; // R15
        end
        if (wr && idx == rtie_pkg::IDX_QCTL) begin
            qctl_next = ((qctl_reg & ~wmask) | wdat) & rtie_pkg::QCTL_WR;
        end
        if (wr && idx == rtie_pkg::IDX_CLR) begin
            clr = wdat; // R17
        end
        // Threshold crossing is edge-detected so a full queue sets the flag once.
        cond_next = qctl_reg[rtie_pkg::B_QTHR_EN] && (rx_queue_bytes_i > thr_reg); // R02
        set = evt_i & rtie_pkg::STAT_IMPL;
        if (cond_next && !cond_reg) begin
            set[rtie_pkg::B_RX] = 1'b1; // R02
        end
        // A set in the same cycle as its clear wins, so no event is lost.
        stat_next = ((stat_reg & ~clr) | set) & rtie_pkg::STAT_IMPL; // R17
        irq_next = |gate; // R16
    end

    // Each status bit reaches the pin only through its enable bit.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_gate
            if (gi == rtie_pkg::B_DELAY) begin : g_delay
                // Delayed energy waits until the host side is ready.
                assign gate[gi] = stat_reg[gi] & en_reg[gi] & host_ready_i; // R14
            end else begin : g_plain
                assign gate[gi] = stat_reg[gi] & en_reg[gi]; // R03 R04 R05 R06 R07 R08 R09 R10 R11 R12 R13
            end
        end
    endgenerate

    // Read data for the addressed register, zero for write-only or unmapped space.
    always_comb begin
        rdat_next = 32'h0000_0000;
        ack_next = req;
        if (req && !wb_we_i) begin
            case (idx)
                rtie_pkg::IDX_THR: rdat_next = {16'h0000, thr_reg};
                rtie_pkg::IDX_EN: rdat_next = {16'h0000, en_reg};
                rtie_pkg::IDX_STAT: rdat_next = {16'h0000, stat_reg};
                rtie_pkg::IDX_QCTL: rdat_next = {16'h0000, qctl_reg};
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    // Register stage for every state of the block.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_reg <= rtie_pkg::THR_RST; // R01
            en_reg <= rtie_pkg::EN_RST; // R15
            qctl_reg <= rtie_pkg::QCTL_RST;
            stat_reg <= rtie_pkg::STAT_RST;
            cond_reg <= 1'b0;
            irq_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            thr_reg <= thr_next;
            en_reg <= en_next;
            qctl_reg <= qctl_next;
            stat_reg <= stat_next;
            cond_reg <= cond_next;
            irq_reg <= irq_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign irq_o = irq_reg;

    // ============================================================
    // Assertions.

    // A full-word write to the threshold lands in the register.
    property p_thr_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr && idx == rtie_pkg::IDX_THR && wb_sel_i[1:0] == 2'b11)
        |=> (thr_reg == $past(wb_dat_i[15:0]));
    endproperty
    a_thr_write: assert property (p_thr_write) // R01
        else $error("Threshold write not stored.");

    // Crossing the enabled threshold sets receive status at the next edge.
    property p_thr_cross;
        @(posedge clk_i) disable iff (rst_i)
        (qctl_reg[rtie_pkg::B_QTHR_EN] && rx_queue_bytes_i > thr_reg && !cond_reg)
        |=> stat_reg[rtie_pkg::B_RX];
    endproperty
    a_thr_cross: assert property (p_thr_cross) // R02
        else $error("Threshold crossing did not set receive status.");

    property p_link_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_LINK] && en_reg[rtie_pkg::B_LINK]) |=> irq_o;
    endproperty
    a_link_gate: assert property (p_link_gate) // R03
        else $error("Enabled link change did not raise the interrupt.");

    property p_tx_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_TX] && en_reg[rtie_pkg::B_TX]) |=> irq_o;
    endproperty
    a_tx_gate: assert property (p_tx_gate) // R04
        else $error("Enabled transmit status did not raise the interrupt.");

    property p_rx_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_RX] && en_reg[rtie_pkg::B_RX]) |=> irq_o;
    endproperty
    a_rx_gate: assert property (p_rx_gate) // R05
        else $error("Enabled receive status did not raise the interrupt.");

    property p_ovr_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_OVR] && en_reg[rtie_pkg::B_OVR]) |=> irq_o;
    endproperty
    a_ovr_gate: assert property (p_ovr_gate) // R06
        else $error("Enabled overrun status did not raise the interrupt.");

    property p_txstop_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_TXSTOP] && en_reg[rtie_pkg::B_TXSTOP]) |=> irq_o;
    endproperty
    a_txstop_gate: assert property (p_txstop_gate) // R07
        else $error("Enabled transmit stop did not raise the interrupt.");

    property p_rxstop_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_RXSTOP] && en_reg[rtie_pkg::B_RXSTOP]) |=> irq_o;
    endproperty
    a_rxstop_gate: assert property (p_rxstop_gate) // R08
        else $error("Enabled receive stop did not raise the interrupt.");

    property p_space_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_TXSPACE] && en_reg[rtie_pkg::B_TXSPACE]) |=> irq_o;
    endproperty
    a_space_gate: assert property (p_space_gate) // R09
        else $error("Enabled transmit space did not raise the interrupt.");

    property p_wframe_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_WFRAME] && en_reg[rtie_pkg::B_WFRAME]) |=> irq_o;
    endproperty
    a_wframe_gate: assert property (p_wframe_gate) // R10
        else $error("Enabled wake frame did not raise the interrupt.");

    property p_rwake_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_RWAKE] && en_reg[rtie_pkg::B_RWAKE]) |=> irq_o;
    endproperty
    a_rwake_gate: assert property (p_rwake_gate) // R11
        else $error("Enabled remote wake did not raise the interrupt.");

    property p_linkup_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_LINKUP] && en_reg[rtie_pkg::B_LINKUP]) |=> irq_o;
    endproperty
    a_linkup_gate: assert property (p_linkup_gate) // R12
        else $error("Enabled link-up wake did not raise the interrupt.");

    property p_energy_gate;
        @(posedge clk_i) disable iff (rst_i)
        (stat_reg[rtie_pkg::B_ENERGY] && en_reg[rtie_pkg::B_ENERGY]) |=> irq_o;
    endproperty
    a_energy_gate: assert property (p_energy_gate) // R13
        else $error("Enabled energy wake did not raise the interrupt.");

    // Delayed energy alone must not reach the pin before the host is ready.
    property p_delay_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!host_ready_i && (stat_reg & en_reg & 16'hFFFE) == 16'h0000)
        |=> !irq_o;
    endproperty
    a_delay_hold: assert property (p_delay_hold) // R14
        else $error("Delayed energy interrupt passed before host ready.");

    // The reserved enable bit never becomes one, whatever is written.
    property p_en_rsv;
        @(posedge clk_i) disable iff (rst_i)
        (wr && idx == rtie_pkg::IDX_EN && wb_dat_i[1] && wb_sel_i[0])
        |=> !en_reg[rtie_pkg::B_RSV1];
    endproperty
    a_en_rsv: assert property (p_en_rsv) // R15
        else $error("Reserved enable bit was written.");

    // Enabled status as the checks see it, built apart from the gate network.
    logic [15:0] live_mask;
    assign live_mask = stat_reg & en_reg;

    // The pin is high only when an enabled status bit was set one edge before.
    property p_irq_cause;
        @(posedge clk_i) disable iff (rst_i)
        irq_o |-> ($past(live_mask) != 16'h0000);
    endproperty
    a_irq_cause: assert property (p_irq_cause) // R16
        else $error("Interrupt raised with no enabled status.");

    // A status read drops no set bit.
    property p_read_keeps;
        @(posedge clk_i) disable iff (rst_i)
        (rd && idx == rtie_pkg::IDX_STAT)
        |=> (($past(stat_reg) & ~stat_reg) == 16'h0000);
    endproperty
    a_read_keeps: assert property (p_read_keeps) // R17
        else $error("Status read cleared a bit.");

    // A clear and an event on the same bit leave the bit set.
    property p_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        (wr && idx == rtie_pkg::IDX_CLR && wdat[rtie_pkg::B_LINK] && evt_i.link_change)
        |=> stat_reg[rtie_pkg::B_LINK];
    endproperty
    a_set_wins: assert property (p_set_wins) // R17
        else $error("Event lost against a clear.");

    // Each request is acknowledged exactly one cycle after it starts.
    property p_ack_time;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !ack_reg) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_time: assert property (p_ack_time)
        else $error("Bus acknowledge timing wrong.");

endmodule : rtie_top

// [verification/rtie_host.sv]
// Host model that issues classic single Wishbone read and write cycles.
`timescale 1ns/1ps
module rtie_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [rtie_pkg::ADR_W-1:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // ============================================================
    // Bus idle at time zero.
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = '0;
        sel_o = 4'h0;
        dat_o = 32'hFFFF_FFFF;
    end

    // One cycle, held until ack is sampled high; released data is inverted so it never lingers.
    task automatic xfer(input logic we, input logic [rtie_pkg::ADR_W-1:0] adr,
                        input logic [3:0] sel, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~wd;
    endtask : xfer
endmodule : rtie_host

// [verification/tb.sv]
// Self-checking bench for the interrupt enable bank and byte threshold block.
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq;
    logic host_ready = 1'b0;
    logic [rtie_pkg::ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rv;
    logic [15:0] q_bytes = 16'h0000;
    rtie_pkg::rtie_evt_t evt = '0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int srcs [12] = '{15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2, 0};

    // The clock toggles every half period of 4 ns.
    always #4 clk_i = ~clk_i;

    rtie_top rtie_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .evt_i(evt), .rx_queue_bytes_i(q_bytes),
        .host_ready_i(host_ready), .irq_o(irq));
    rtie_host rtie_host_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // ============================================================
    // Access, stimulus and compare tasks.
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic exp);
        cmp_count++;
        if (irq !== exp) begin
            n_mismatch++;
            $display("BAD %0t interrupt line %b expected %b", $time, irq, exp);
        end
    endtask : chk_irq

    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s = 4'h3);
        rtie_host_i.xfer(1'b1, {idx, 2'b00}, s, {16'h0000, d}, rv);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        rtie_host_i.xfer(1'b0, {idx, 2'b00}, 4'h3, 32'h0000_0000, rv);
        chk_reg(rv, {16'h0000, exp});
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Raises one event line for exactly one cycle.
    task automatic pulse(input int b);
        @(posedge clk_i);
        evt <= rtie_pkg::rtie_evt_t'(16'h0001 << b);
        @(posedge clk_i);
        evt <= '0;
    endtask : pulse

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // ============================================================
    // Watchdog cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end

    // Main test sequence.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(rtie_pkg::IDX_THR, 16'h0000);
        rd(rtie_pkg::IDX_EN, 16'h0000);
        chk_irq(1'b0);
        wr(rtie_pkg::IDX_STAT, 16'hFFFF);
        rd(rtie_pkg::IDX_STAT, rtie_pkg::STAT_RST);
        rd(rtie_pkg::IDX_CLR, 16'h0000);
        rd(8'h10, 16'h0000);
        $display("test reset values done");
        wr(rtie_pkg::IDX_THR, 16'hFFFF);
        rd(rtie_pkg::IDX_THR, 16'hFFFF);
        wr(rtie_pkg::IDX_THR, 16'h1234, 4'h1);
        rd(rtie_pkg::IDX_THR, 16'hFF34);
        wr(rtie_pkg::IDX_THR, 16'h5678, 4'h2);
        rd(rtie_pkg::IDX_THR, 16'h5634);
        wr(rtie_pkg::IDX_EN, 16'hFFFF);
        rd(rtie_pkg::IDX_EN, 16'hFFFD);
        $display("test register access done");
        host_ready <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wr(rtie_pkg::IDX_EN, rtie_pkg::EN_WR & ~(16'h0001 << srcs[i]));
            wr(rtie_pkg::IDX_CLR, 16'hFFFF);
            pulse(srcs[i]);
            tick(3);
            chk_irq(1'b0);
            rd(rtie_pkg::IDX_STAT, 16'h0001 << srcs[i]);
            rd(rtie_pkg::IDX_STAT, 16'h0001 << srcs[i]);
            wr(rtie_pkg::IDX_EN, 16'h0001 << srcs[i]);
            tick(3);
            chk_irq(1'b1);
            wr(rtie_pkg::IDX_CLR, 16'h0001 << srcs[i]);
            tick(3);
            chk_irq(1'b0);
        end
        $display("test source gating done");
        host_ready <= 1'b0;
        wr(rtie_pkg::IDX_EN, 16'h0001);
        pulse(0);
        tick(3);
        chk_irq(1'b0);
        host_ready <= 1'b1;
        tick(3);
        chk_irq(1'b1);
        $display("test delayed energy done");
        wr(rtie_pkg::IDX_EN, 16'h0000);
        wr(rtie_pkg::IDX_CLR, 16'hFFFF);
        wr(rtie_pkg::IDX_THR, 16'h0064);
        q_bytes <= 16'h0065;
        tick(3);
        rd(rtie_pkg::IDX_STAT, 16'h0000);
        q_bytes <= 16'h0064;
        wr(rtie_pkg::IDX_QCTL, 16'hFFFF);
        rd(rtie_pkg::IDX_QCTL, 16'h0040);
        tick(3);
        rd(rtie_pkg::IDX_STAT, 16'h0000);
        q_bytes <= 16'h0065;
        tick(3);
        rd(rtie_pkg::IDX_STAT, 16'h2000);
        wr(rtie_pkg::IDX_CLR, 16'h2000);
        tick(3);
        rd(rtie_pkg::IDX_STAT, 16'h0000);
        $display("test byte threshold done");
        // An event held high across a clear write must survive the clear.
        wr(rtie_pkg::IDX_EN, 16'h8000);
        evt <= rtie_pkg::rtie_evt_t'(16'h8000);
        wr(rtie_pkg::IDX_CLR, 16'h8000);
        evt <= '0;
        rd(rtie_pkg::IDX_STAT, 16'h8000);
        chk_irq(1'b1);
        // A reset in mid-run returns every register to its reset value.
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        rd(rtie_pkg::IDX_THR, 16'h0000);
        rd(rtie_pkg::IDX_EN, 16'h0000);
        rd(rtie_pkg::IDX_STAT, rtie_pkg::STAT_RST);
        rd(rtie_pkg::IDX_QCTL, 16'h0000);
        chk_irq(1'b0);
        $display("test set wins and reset done");
        results();
    end
endmodule : tb
